/* File: src/ucd_regs.vh */
`ifndef UCD_REGS_VH
`define UCD_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UCD_A_DATA 8'h00
`define UCD_A_IER 8'h04
`define UCD_A_FIFO 8'h08
`define UCD_A_LCR 8'h0C
`define UCD_A_MCR 8'h10
`define UCD_A_LSR 8'h14
`define UCD_A_MSR 8'h18
`define UCD_A_FEATURE_CONTROL 8'h1C
`define UCD_A_EFR 8'h20
`define UCD_A_TTRG 8'h24
`define UCD_A_RTRG 8'h28
`define UCD_A_XOFF 8'h2C
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define UCD_LCR_DLAB 7
`define UCD_FEATURE_CONTROL_485 5
`define UCD_EFR_ENH 4
`define UCD_MCR_SEL 2
`define UCD_MCR_X8 3
`define UCD_RST_DIV 16'h0001
`define UCD_RST_TRG 8'h01
`define UCD_RST_XOFF 8'h13
`define UCD_RST_LCR 8'h03
// ----------------------------------------
// FIFO depth and timing counts
// ----------------------------------------
`define UCD_FIFO_DEPTH 7'h40
`define UCD_LAST16 4'hF
`define UCD_LAST8 4'h7
`define UCD_HALF16 4'h7
`define UCD_HALF8 4'h3
`define UCD_TOUT_CHARS 8'h04
`define UCD_TOUT_BITS 8'h0C
`define UCD_FRAME_OVH 8'h07
`endif

/* File: src/ucd_baud.v */
`timescale 1ns/1ns
`include "ucd_regs.vh"
module ucd_baud (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Rate setup
  input wire [15:0] divisor,
  input wire mode8,
  // Ticks
  output reg os_tick,
  output reg bit_tick
);
  reg [15:0] cnt_q;
  reg [3:0] sub_q;
  wire [15:0] lim = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
  wire [3:0] last = mode8 ? `UCD_LAST8 : `UCD_LAST16;

  // Divisor counter; zero divisor behaves as one
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 16'h0000;
      sub_q <= 4'h0;
      os_tick <= 1'b0;
      bit_tick <= 1'b0;
    end else begin
      os_tick <= (cnt_q >= lim);
      bit_tick <= (cnt_q >= lim) && (sub_q >= last);
      if (cnt_q >= lim) begin
        cnt_q <= 16'h0000;
        sub_q <= (sub_q >= last) ? 4'h0 : sub_q + 4'h1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule

/* File: src/ucd_fifo.v */
`timescale 1ns/1ns
`include "ucd_regs.vh"
module ucd_fifo #(
  parameter W = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Control
  input wire flush,
  input wire push,
  input wire [W-1:0] wdata,
  input wire pop,
  // State
  output wire [W-1:0] rdata,
  output reg [6:0] count
);
  reg [W-1:0] mem [0:63];
  reg [5:0] wp_q;
  reg [5:0] rp_q;
  wire do_push = push && (count != `UCD_FIFO_DEPTH);
  wire do_pop = pop && (count != 7'h00);

  assign rdata = mem[rp_q];

  // Storage has no reset; only pointers and count carry state
  always @(posedge sys_clk) begin
    if (do_push) begin
      mem[wp_q] <= wdata;
    end
  end

  // Pointers and fill level
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= 6'h00;
      rp_q <= 6'h00;
      count <= 7'h00;
    end else if (flush) begin
      wp_q <= 6'h00;
      rp_q <= 6'h00;
      count <= 7'h00;
    end else begin
      if (do_push) begin
        wp_q <= wp_q + 6'h01;
      end
      if (do_pop) begin
        rp_q <= rp_q + 6'h01;
      end
      if (do_push && !do_pop) begin
        count <= count + 7'h01;
      end else if (do_pop && !do_push) begin
        count <= count - 7'h01;
      end
    end
  end
endmodule

/* File: src/ucd_top.v */
`timescale 1ns/1ns
`include "ucd_regs.vh"
module ucd_top (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Serial line
  input wire rxd,
  output reg txd,
  // Modem pins
  input wire cts_n,
  output reg rts_n,
  output reg dtr_n,
  // Interrupt request
  output reg irq
);
  localparam T_IDLE = 6'b000001;
  localparam T_START = 6'b000010;
  localparam T_DATA = 6'b000100;
  localparam T_PAR = 6'b001000;
  localparam T_STOP = 6'b010000;
  localparam T_TURN = 6'b100000;
  localparam R_IDLE = 5'b00001;
  localparam R_START = 5'b00010;
  localparam R_DATA = 5'b00100;
  localparam R_PAR = 5'b01000;
  localparam R_STOP = 5'b10000;

  // Full test differs: one entry without FIFOs, 64 with
  function full_f(input [6:0] cnt, input en);
    full_f = en ? (cnt == `UCD_FIFO_DEPTH) : (cnt != 7'h00);
  endfunction

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [7:0] ier_q, lcr_q, mcr_q, feature_control_q, efr_q, ttrg_q, rtrg_q, xchr_q;
  reg [15:0] div_q;
  reg [3:0] dly_q;
  reg fen_q, ovr_q, xoff_q, cts_chg_q, rts_chg_q, tout_q, dir_q;
  reg rx_s1, rx_s2, rx_s3, cts_s1, cts_s2, cts_s3;
  reg [5:0] ts_q;
  reg [7:0] tsh_q;
  reg [2:0] tbit_q;
  reg [3:0] tos_q, tdly_q;
  reg tstop_q, tpar_q;
  reg [4:0] rs_q;
  reg [7:0] rsh_q;
  reg [2:0] rbit_q;
  reg [3:0] ros_q;
  reg rpar_q, rpe_q;
  reg [6:0] err_q;
  reg [7:0] tcnt_q;
  reg [7:0] rd_d;
  reg hit_d, txd_d;

  wire os_tick, bit_tick;
  wire [7:0] tx_head;
  wire [10:0] rx_head;
  wire [6:0] tx_cnt, rx_cnt;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire setup = psel && !penable;
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite && hit_d;
  wire rd = acc && !pwrite && hit_d;
  wire dlab = lcr_q[`UCD_LCR_DLAB];
  wire enh = efr_q[`UCD_EFR_ENH];
  wire rs485 = feature_control_q[`UCD_FEATURE_CONTROL_485];
  wire x8 = mcr_q[`UCD_MCR_X8];
  wire sel_dtr = mcr_q[`UCD_MCR_SEL];
  wire [3:0] half = x8 ? `UCD_HALF8 : `UCD_HALF16;
  wire [3:0] last = x8 ? `UCD_LAST8 : `UCD_LAST16;
  wire w_data = wr && (paddr == `UCD_A_DATA);
  wire w_fcr = wr && (paddr == `UCD_A_FIFO);
  wire r_data = rd && (paddr == `UCD_A_DATA) && !dlab;
  wire r_lsr = rd && (paddr == `UCD_A_LSR);
  wire r_msr = rd && (paddr == `UCD_A_MSR);
  wire r_isr = rd && (paddr == `UCD_A_FIFO);
  wire flush_tx = w_fcr && pwdata[0] && (pwdata[2] || !fen_q);
  wire flush_rx = w_fcr && pwdata[0] && (pwdata[1] || !fen_q);
  wire tx_push = w_data && !dlab && !full_f(tx_cnt, fen_q);
  wire rx_pop = r_data && (rx_cnt != 7'h00);

  // ----------------------------------------
  // Transmit side
  // ----------------------------------------
  wire t_end = os_tick && (tos_q == last);
  wire t_go = (ts_q == T_IDLE || ts_q == T_TURN) && (tx_cnt != 7'h00);
  wire t_next = (ts_q == T_STOP) && t_end && !tstop_q && (tx_cnt != 7'h00);
  wire tx_pop = t_go || t_next;
  wire tx_idle = (ts_q == T_IDLE) || (ts_q == T_TURN);
  wire [2:0] wl_last = {1'b1, lcr_q[1:0]};
  wire tpbit = lcr_q[5] ? !lcr_q[4] : (lcr_q[4] ? tpar_q : !tpar_q);

  // ----------------------------------------
  // Receive side
  // ----------------------------------------
  wire r_end = os_tick && (ros_q == last);
  wire [7:0] r_data8 = rsh_q >> (2'd3 - lcr_q[1:0]);
  wire r_fe = !rx_s2;
  wire r_brk = (r_data8 == 8'h00) && !rx_s2;
  wire r_push = (rs_q == R_STOP) && r_end;
  wire rx_full = full_f(rx_cnt, fen_q);
  wire [10:0] r_word = {r_brk, r_fe, rpe_q, r_data8};
  wire r_err = r_fe || rpe_q || r_brk;
  wire h_err = (rx_cnt != 7'h00) && (rx_head[10:8] != 3'b000);
  wire below = {1'b0, rx_cnt} < rtrg_q;
  wire [7:0] tlim = `UCD_TOUT_CHARS * ({6'h00, lcr_q[1:0]} + `UCD_FRAME_OVH)
                  + `UCD_TOUT_BITS;

  // ----------------------------------------
  // Status and interrupt sources
  // ----------------------------------------
  wire lsr6 = (tx_cnt == 7'h00) && tx_idle;
  wire lsr5 = (tx_cnt == 7'h00);
  wire [7:0] line_status = {err_q != 7'h00, lsr6, lsr5,
                    h_err ? rx_head[10:8] : 3'b000, ovr_q,
                    rx_cnt != 7'h00};
  wire rx_av = fen_q ? !below : (rx_cnt != 7'h00);
  wire thr_src = rs485 ? lsr6
               : (fen_q ? ({1'b0, tx_cnt} < ttrg_q) : lsr5);
  wire [7:0] src = {cts_chg_q, rts_chg_q, xoff_q, tout_q,
                    cts_chg_q, ovr_q || h_err, thr_src, rx_av};
  wire [7:0] ien = {ier_q[7:5] & {3{enh}},
                    ier_q[0], ier_q[3:0]};
  // Drop unless a turnaround is owed, so no stale direction is left over
  wire dir_drop = (ts_q == T_STOP) && t_end && !tstop_q && !t_next
                  && (!rs485 || dly_q == 4'h0);
  wire rts_n_d = (rs485 && !sel_dtr) ? !dir_q : !mcr_q[1];
  wire dtr_n_d = (rs485 && sel_dtr) ? !dir_q : !mcr_q[0];

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  ucd_baud u_baud (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .divisor(div_q),
    .mode8(x8),
    .os_tick(os_tick),
    .bit_tick(bit_tick)
  );

  ucd_fifo #(.W(8)) u_txf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .flush(flush_tx),
    .push(tx_push),
    .wdata(pwdata[7:0]),
    .pop(tx_pop),
    .rdata(tx_head),
    .count(tx_cnt)
  );

  ucd_fifo #(.W(11)) u_rxf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .flush(flush_rx),
    .push(r_push && !rx_full),
    .wdata(r_word),
    .pop(rx_pop),
    .rdata(rx_head),
    .count(rx_cnt)
  );

  // Read mux; divisor overlays data and enable words
  always @* begin
    hit_d = 1'b1;
    case (paddr)
      `UCD_A_DATA: rd_d = dlab ? div_q[7:0] : rx_head[7:0];
      `UCD_A_IER: rd_d = dlab ? div_q[15:8] : ier_q;
      `UCD_A_FIFO: rd_d = src;
      `UCD_A_LCR: rd_d = lcr_q;
      `UCD_A_MCR: rd_d = mcr_q;
      `UCD_A_LSR: rd_d = line_status;
      `UCD_A_MSR: rd_d = {dly_q, !cts_s2, 1'b0, rts_chg_q, cts_chg_q};
      `UCD_A_FEATURE_CONTROL: rd_d = feature_control_q;
      `UCD_A_EFR: rd_d = efr_q;
      `UCD_A_TTRG: rd_d = {1'b0, tx_cnt};
      `UCD_A_RTRG: rd_d = {1'b0, rx_cnt};
      `UCD_A_XOFF: rd_d = xchr_q;
      default: begin
        rd_d = 8'h00;
        hit_d = 1'b0;
      end
    endcase
  end

  // Line level from transmit state; break forces low
  always @* begin
    case (ts_q)
      T_START: txd_d = 1'b0;
      T_DATA: txd_d = tsh_q[0];
      T_PAR: txd_d = tpbit;
      default: txd_d = 1'b1;
    endcase
  end

  // APB answer with no wait state, data latched at setup
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit_d;
      if (setup) begin
        prdata <= {24'h000000, rd_d};
      end
    end
  end

  // Software-written registers
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ier_q <= 8'h00;
      lcr_q <= `UCD_RST_LCR;
      mcr_q <= 8'h00;
      feature_control_q <= 8'h00;
      efr_q <= 8'h00;
      ttrg_q <= `UCD_RST_TRG;
      rtrg_q <= `UCD_RST_TRG;
      xchr_q <= `UCD_RST_XOFF;
      div_q <= `UCD_RST_DIV;
      dly_q <= 4'h0;
      fen_q <= 1'b0;
    end else if (wr) begin
      case (paddr)
        `UCD_A_DATA: if (dlab) div_q[7:0] <= pwdata[7:0];
        `UCD_A_IER: begin
          if (dlab) begin
            div_q[15:8] <= pwdata[7:0];
          end else begin
            ier_q <= pwdata[7:0];
          end
        end
        `UCD_A_FIFO: fen_q <= pwdata[0];
        `UCD_A_LCR: lcr_q <= pwdata[7:0];
        `UCD_A_MCR: mcr_q <= pwdata[7:0];
        `UCD_A_MSR: dly_q <= pwdata[7:4];
        `UCD_A_FEATURE_CONTROL: feature_control_q <= pwdata[7:0];
        `UCD_A_EFR: efr_q <= pwdata[7:0];
        `UCD_A_TTRG: ttrg_q <= pwdata[7:0];
        `UCD_A_RTRG: rtrg_q <= pwdata[7:0];
        `UCD_A_XOFF: xchr_q <= pwdata[7:0];
        default: fen_q <= fen_q;
      endcase
    end
  end

  // Two-flop synchronisers; third flop only feeds edge detect
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
      cts_s3 <= 1'b1;
    end else begin
      rx_s1 <= rxd;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      cts_s1 <= cts_n;
      cts_s2 <= cts_s1;
      cts_s3 <= cts_s2;
    end
  end

  // Transmit sequencer
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ts_q <= T_IDLE;
      tsh_q <= 8'h00;
      tbit_q <= 3'h0;
      tos_q <= 4'h0;
      tstop_q <= 1'b0;
      tpar_q <= 1'b0;
      tdly_q <= 4'h0;
      dir_q <= 1'b0;
    end else begin
      tos_q <= (tx_pop || t_end) ? 4'h0
             : (os_tick ? tos_q + 4'h1 : tos_q);
      case (ts_q)
        T_IDLE, T_TURN: begin
          if (t_go) begin
            ts_q <= T_START;
            tsh_q <= tx_head;
            tpar_q <= 1'b0;
            dir_q <= 1'b1;
          end else if (ts_q == T_TURN && t_end) begin
            tdly_q <= tdly_q - 4'h1;
            if (tdly_q == 4'h1) begin
              ts_q <= T_IDLE;
              dir_q <= 1'b0;
            end
          end
        end
        T_START: begin
          if (t_end) begin
            ts_q <= T_DATA;
            tbit_q <= 3'h0;
          end
        end
        T_DATA: begin
          if (t_end) begin
            tpar_q <= tpar_q ^ tsh_q[0];
            tsh_q <= {1'b0, tsh_q[7:1]};
            tbit_q <= tbit_q + 3'h1;
            if (tbit_q == wl_last) begin
              ts_q <= lcr_q[3] ? T_PAR : T_STOP;
              tstop_q <= lcr_q[2];
            end
          end
        end
        T_PAR: begin
          if (t_end) begin
            ts_q <= T_STOP;
          end
        end
        T_STOP: begin
          if (t_end) begin
            if (tstop_q) begin
              tstop_q <= 1'b0;
            end else if (t_next) begin
              ts_q <= T_START;
              tsh_q <= tx_head;
              tpar_q <= 1'b0;
            end else if (rs485 && dly_q != 4'h0) begin
              ts_q <= T_TURN;
              tdly_q <= dly_q;
            end else begin
              ts_q <= T_IDLE;
              if (dir_drop) begin
                dir_q <= 1'b0;
              end
            end
          end
        end
        default: ts_q <= T_IDLE;
      endcase
    end
  end

  // Receive sequencer, sampling mid-bit
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rs_q <= R_IDLE;
      rsh_q <= 8'h00;
      rbit_q <= 3'h0;
      ros_q <= 4'h0;
      rpar_q <= 1'b0;
      rpe_q <= 1'b0;
    end else begin
      case (rs_q)
        R_IDLE: begin
          ros_q <= 4'h0;
          if (rx_s3 && !rx_s2) begin
            rs_q <= R_START;
          end
        end
        R_START: begin
          if (os_tick) begin
            ros_q <= ros_q + 4'h1;
            if (ros_q == half) begin
              ros_q <= 4'h0;
              rs_q <= rx_s2 ? R_IDLE : R_DATA;
              rbit_q <= 3'h0;
              rpar_q <= 1'b0;
              rpe_q <= 1'b0;
            end
          end
        end
        R_DATA: begin
          ros_q <= r_end ? 4'h0 : (os_tick ? ros_q + 4'h1 : ros_q);
          if (r_end) begin
            rsh_q <= {rx_s2, rsh_q[7:1]};
            rpar_q <= rpar_q ^ rx_s2;
            rbit_q <= rbit_q + 3'h1;
            if (rbit_q == wl_last) begin
              rs_q <= lcr_q[3] ? R_PAR : R_STOP;
            end
          end
        end
        R_PAR: begin
          ros_q <= r_end ? 4'h0 : (os_tick ? ros_q + 4'h1 : ros_q);
          if (r_end) begin
            rpe_q <= lcr_q[5] ? (rx_s2 == lcr_q[4])
                   : (lcr_q[4] ? (rpar_q ^ rx_s2) : !(rpar_q ^ rx_s2));
            rs_q <= R_STOP;
          end
        end
        R_STOP: begin
          ros_q <= r_end ? 4'h0 : (os_tick ? ros_q + 4'h1 : ros_q);
          if (r_end) begin
            rs_q <= R_IDLE; // Break must go high before a new start
          end
        end
        default: rs_q <= R_IDLE;
      endcase
    end
  end

  // Error count, time-out and sticky event flags; set beats clear
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      err_q <= 7'h00;
      tcnt_q <= 8'h00;
      tout_q <= 1'b0;
      ovr_q <= 1'b0;
      xoff_q <= 1'b0;
      cts_chg_q <= 1'b0;
      rts_chg_q <= 1'b0;
    end else begin
      if (flush_rx) begin
        err_q <= 7'h00;
      end else begin
        err_q <= err_q + {6'h00, r_push && !rx_full && r_err}
               - {6'h00, rx_pop && h_err};
      end
      if (r_push || rx_pop || !fen_q || rx_cnt == 7'h00 || !below) begin
        tcnt_q <= 8'h00;
        tout_q <= 1'b0;
      end else if (bit_tick && tcnt_q != tlim) begin
        tcnt_q <= tcnt_q + 8'h01;
      end else if (tcnt_q == tlim) begin
        tout_q <= 1'b1;
      end
      ovr_q <= (r_push && rx_full) || (ovr_q && !r_lsr);
      xoff_q <= (r_push && !r_fe && r_data8 == xchr_q)
                || (xoff_q && !r_isr);
      cts_chg_q <= (cts_s2 != cts_s3) || (cts_chg_q && !r_msr);
      rts_chg_q <= (rts_n_d != rts_n) || (rts_chg_q && !r_msr);
    end
  end

  // Pin and interrupt outputs
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txd <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      txd <= txd_d && !lcr_q[6];
      rts_n <= rts_n_d;
      dtr_n <= dtr_n_d;
      irq <= (src & ien) != 8'h00;
    end
  end
endmodule

/* File: tb/ucd_monitor.sv */
`timescale 1ns/1ns
// ------
// Port checker
// ------
module ucd_monitor (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Line and interrupt
  input wire txd,
  input wire irq
);
  reg dlab_q;
  reg [7:0] ier_q;
  wire wr_acc = psel && penable && pready && pwrite;
  wire lsr_rd = pready && !pwrite && paddr == 8'h14;
  // Shadow of divisor access and mask, so irq can be judged
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dlab_q <= 1'b0;
      ier_q <= 8'h00;
    end else if (wr_acc && paddr == 8'h0C) begin
      dlab_q <= pwdata[7];
    end else if (wr_acc && paddr == 8'h04 && !dlab_q) begin
      ier_q <= pwdata[7:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error reply");
  chk_start_len:
    assert property ($fell(txd) |-> (!txd) [*8] ##1 (!txd) [*8])
    else $error("short low bit");
  chk_stop_len:
    assert property ($rose(txd) |-> txd [*8] ##1 txd [*8])
    else $error("short high bit");
  chk_shift_empty:
    assert property (lsr_rd && prdata[6] |-> prdata[5] && txd)
    else $error("shifter empty while busy");
  chk_irq_mask:
    assert property ((ier_q == 8'h00) [*3] |-> !irq)
    else $error("irq with all sources masked");
  chk_dlab_hold:
    assert property (wr_acc && dlab_q && paddr == 8'h00 && txd
      |=> txd [*8])
    else $error("divisor write sent a frame");
  cov_lsr: cover property (lsr_rd && prdata[6]);
  cov_err: cover property (pslverr);
  cov_frame: cover property ($fell(txd));
endmodule
bind ucd_top ucd_monitor u_ucd_monitor (.sys_clk(sys_clk),
  .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txd(txd), .irq(irq));

/* File: tb/ucd_remote.sv */
`timescale 1ns/1ns
// ------
// Remote station, 16 clocks a bit
// ------
module ucd_remote (
  // Line
  input wire sys_clk,
  input wire txd,
  output reg rxd
);
  reg [7:0] rx_bytes [$];
  reg [7:0] sh;
  integer i;
  initial rxd = 1'b1;
  // Decoder samples mid-bit; bad stop drops the byte
  always begin
    @(negedge txd);
    repeat (8) @(posedge sys_clk);
    if (!txd) begin
      for (i = 0; i < 8; i = i + 1) begin
        repeat (16) @(posedge sys_clk);
        sh[i] = txd;
      end
      repeat (16) @(posedge sys_clk);
      if (txd) rx_bytes.push_back(sh);
    end
  end
  // One 8N1 frame; a low stop forges a framing fault
  task send(input [7:0] b, input stop);
    integer k;
    begin
      @(posedge sys_clk);
      rxd <= 1'b0;
      repeat (16) @(posedge sys_clk);
      for (k = 0; k < 8; k = k + 1) begin
        rxd <= b[k];
        repeat (16) @(posedge sys_clk);
      end
      rxd <= stop;
      repeat (16) @(posedge sys_clk);
      rxd <= 1'b1;
      repeat (16) @(posedge sys_clk);
    end
  endtask
  // Short low pulse, too brief to pass as a start
  task glitch;
    begin
      @(posedge sys_clk);
      rxd <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rxd <= 1'b1;
      repeat (32) @(posedge sys_clk);
    end
  endtask
endmodule

/* File: tb/ucd_top_test.sv */
`timescale 1ns/1ns
module ucd_top_test;
  reg sys_clk = 1'b0;
  reg resetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg cts_n = 1'b1;
  reg rerr;
  reg [31:0] rd;
  wire [31:0] prdata;
  wire pready, pslverr, rxd, txd, rts_n, dtr_n, irq;
  integer err_total = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer n, t;
  ucd_top u_ucd_top (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .dtr_n(dtr_n), .irq(irq));
  ucd_remote u_ucd_remote (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));
  // 250 MHz clock and a run ceiling against hangs
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      test_done;
    end
  end
  // ------
  // Tasks
  // ------
  task check(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Setup then access; held until pready is seen
  task apb(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 8'h00);
      check(rd, e);
    end
  endtask
  // Polls line status until one bit is set
  task wait_lsr(input integer b);
    begin
      rd = 32'h0;
      while (rd[b] !== 1'b1) apb(1'b0, 8'h14, 8'h00);
    end
  endtask
  task test_done;
    begin
      $display("mismatches %0d checks %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc(8'h04, 32'h0);
    rdc(8'h14, 32'h60);
    apb(1'b0, 8'h30, 8'h00);
    check(rerr, 1'b1);
    wr(8'h0C, 8'h83);
    wr(8'h00, 8'h3C);
    rdc(8'h00, 32'h3C);
    wr(8'h00, 8'h01);
    wr(8'h0C, 8'h03);
    $display("registers done");
    // Single byte, no FIFO
    wr(8'h00, 8'hA5);
    wait_lsr(5);
    check(rd[6], 1'b0);
    wait_lsr(6);
    check(u_ucd_remote.rx_bytes.size(), 1);
    check(u_ucd_remote.rx_bytes.pop_front(), 8'hA5);
    $display("single byte done");
    // Overfill the transmit FIFO, then drain
    wr(8'h24, 8'h04);
    wr(8'h04, 8'h02);
    wr(8'h08, 8'h01);
    for (n = 0; n < 68; n = n + 1) wr(8'h00, n[7:0]);
    rdc(8'h24, 32'd64);
    check(irq, 1'b0);
    wait_lsr(5);
    check(rd[6], 1'b0);
    wait_lsr(6);
    check(irq, 1'b1);
    check(u_ucd_remote.rx_bytes.size(), 66);
    for (n = 0; n < 66; n = n + 1)
      check(u_ucd_remote.rx_bytes.pop_front(), n[7:0]);
    $display("fifo transmit done");
    // Receive: false start, framing fault, trigger, time-out
    wr(8'h04, 8'h01);
    wr(8'h28, 8'h02);
    u_ucd_remote.glitch;
    u_ucd_remote.send(8'h3C, 1'b1);
    rdc(8'h28, 32'h1);
    check(irq, 1'b0);
    u_ucd_remote.send(8'h5A, 1'b0);
    rdc(8'h14, 32'hE1);
    check(irq, 1'b1);
    rdc(8'h00, 32'h3C);
    rdc(8'h14, 32'hE9);
    check(irq, 1'b0);
    wr(8'h04, 8'h05);
    repeat (2) @(posedge sys_clk);
    check(irq, 1'b1);
    wr(8'h04, 8'h01);
    repeat (700) @(posedge sys_clk);
    check(irq, 1'b0);
    repeat (200) @(posedge sys_clk);
    check(irq, 1'b1);
    rdc(8'h00, 32'h5A);
    rdc(8'h14, 32'h60);
    $display("receive done");
    // Direction control, turnaround of 0 and 3 bits
    wr(8'h04, 8'h02);
    wr(8'h1C, 8'h20);
    // Second pass steers direction onto the terminal-ready pin
    for (n = 0; n < 6; n = n + 3) begin
      wr(8'h18, {n[3:0], 4'h0});
      wr(8'h10, {5'h00, n[0], 2'b00});
      wr(8'h00, 8'h0F);
      while (txd !== 1'b0) @(posedge sys_clk);
      t = cyc;
      repeat (80) @(posedge sys_clk);
      check(irq, 1'b0);
      check(n[0] ? dtr_n : rts_n, 1'b0);
      check(n[0] ? rts_n : dtr_n, 1'b1);
      while ((n[0] ? dtr_n : rts_n) !== 1'b1) @(posedge sys_clk);
      t = cyc - t - 160 - 16 * n;
      check(t >= -2 && t <= 2, 1'b1);
      check(irq, 1'b1);
    end
    $display("direction done");
    // Modem change interrupts: mask bit 3, then enhanced bits 7 and 6
    wr(8'h04, 8'h08);
    cts_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check(irq, 1'b1);
    rdc(8'h18, 32'h3B);
    wr(8'h20, 8'h10);
    wr(8'h04, 8'h80);
    check(irq, 1'b0);
    cts_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(irq, 1'b1);
    wr(8'h04, 8'h40);
    repeat (2) @(posedge sys_clk);
    check(irq, 1'b0);
    wr(8'h10, 8'h06);
    repeat (3) @(posedge sys_clk);
    check(rts_n, 1'b0);
    check(irq, 1'b1);
    $display("modem done");
    test_done;
  end
endmodule
